// File: src/sport_defs.svh
// Offsets, field positions, reset values and timing counts of the serial port control block.
`ifndef SPORT_DEFS_SVH
`define SPORT_DEFS_SVH
`define CTRL_OFS          8'h00
`define STAT_OFS          8'h04
`define TXDATA_OFS        8'h08
`define RXDATA_OFS        8'h0C
`define BAUD_OFS          8'h10
`define CTRL_RESET        8'h00
`define BAUD_RESET        16'h0010
`define BIT_MODE_HI       7
`define BIT_MODE_LO       6
`define BIT_MP_EN         5
`define BIT_RX_EN         4
`define BIT_TX9           3
`define BIT_RX9           2
`define BIT_TX_DONE       1
`define BIT_RX_DONE       0
`define FIXED_DIV_M0      16'h0010
`define FIXED_DIV_M2      16'h0020
`define FIFO_DEPTH        4
`define FIFO_AW           2
`endif

// File: src/sport_pkg.sv
// Types shared by the serial port control block.
package sport_pkg;
	typedef enum logic [1:0] {MODE_SHIFT, MODE_UART8, MODE_UART9_FIX, MODE_UART9_VAR} mode_t;
	typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage : sport_pkg

// File: src/sport_fifo.sv
// Small valid/ready FIFO whose read data come from a register.
`timescale 1ns/100ps
module sport_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4,
	parameter int AW    = 2
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
		logic [WIDTH-1:0]            dout;
		logic                        dval;
	} fifo_state_t;
	fifo_state_t s_q, s_d;
	logic push;
	logic pop;
	logic [AW:0] depth_c;

	assign depth_c   = (AW+1)'(DEPTH);
	assign in_ready  = (s_q.cnt != depth_c);
	assign out_data  = s_q.dout;
	assign out_valid = s_q.dval;
	assign push      = in_valid && in_ready;

	// The output register is refilled from the store as soon as it empties.
	always_comb
	begin
		s_d = s_q;
		pop = (!s_q.dval || out_ready) && (s_q.cnt != '0);
		if (out_ready)
			s_d.dval = 1'b0;
		if (pop)
		begin
			s_d.dout = s_q.mem[s_q.rp];
			s_d.dval = 1'b1;
			s_d.rp   = s_q.rp + 1'b1;
		end
		if (push)
		begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp          = s_q.wp + 1'b1;
		end
		s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
endmodule : sport_fifo

// File: src/sport_ctrl.sv
// Serial port control register, ninth-bit handling, filter and completion flags.
//
// Summary of operation
// - Two mode bits select shift register, 8-bit UART, or 9-bit fixed/variable rate.
// - In 9-bit modes with filter enabled, ninth bit zero suppresses receive flag.
// - In 8-bit mode with filter enabled, receive flag needs a valid stop bit.
// - Receive enable bit gates acceptance of new incoming frames.
// - Software ninth-bit value is sent as ninth bit; single stage, unbuffered.
// - Ninth received bit stored; in 8-bit unfiltered mode the stop bit instead.
// - Shift mode leaves received ninth-bit field untouched; filter should stay zero.
// - Transmit flag sets when transmitter can accept another byte.
// - Hardware never clears completion flags; software clears them.
// - Receive flag sets after eighth bit (shift) or stop bit (UART), filtered.
`timescale 1ns/100ps
`include "sport_defs.svh"
module sport_ctrl
	import sport_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        rxd_i,
	output logic             txd_o,
	output logic             shift_clk_o
);
	////////////////////////////////////////////////////////////////////////////////
	// The control register holds, from bit 7 down: two mode bits, filter enable, receive
	// enable, transmit ninth bit, received ninth bit, transmit done and receive done.
	// Writing zero to a done flag clears it, but a hardware set in the same cycle wins,
	// so an event that lands during the clear is never lost.
	// Clearing the receive enable only blocks new start bits; a frame already being
	// sampled still completes and may raise the receive flag.
	// Changing the mode while a frame is on the line alters the bit time of the rest
	// of that frame, so software should wait until the status shows both sides idle.
	// The queue's output register holds one byte beyond its four slots, so up to six
	// bytes can be in flight counting the one in the shifter.
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [15:0] baud;
		logic [31:0] dat;
		logic        ack;
		logic [15:0] div;
		tx_state_t   tst;
		logic [10:0] tsh;
		logic [3:0]  tcnt;
		logic [3:0]  tbits;
		logic        txd;
		logic        sclk;
		rx_state_t   rst;
		logic [3:0]  rph;
		logic [3:0]  rcnt;
		logic [8:0]  rsh;
		logic        rxd_p;
		logic [7:0]  rxbuf;
	} ctrl_state_t;
	ctrl_state_t s_q, s_d;

	logic [7:0] fifo_out;
	logic       fifo_valid;
	logic       fifo_pop;
	logic       fifo_in_ready;
	logic       push_tx;
	logic       tick;
	logic [15:0] div_lim;
	mode_t      mode;
	logic       wr;
	logic       rd;
	logic       hw_set_tx;
	logic       hw_set_rx;
	logic       rx_ninth_bit_d;
	logic       rx_ninth_we;
	logic [3:0] stat_c;

	function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
		hit = (adr[7:2] == ofs[7:2]);
	endfunction : hit

	function automatic logic is_nine(input mode_t m);
		is_nine = (m == MODE_UART9_FIX) || (m == MODE_UART9_VAR);
	endfunction : is_nine

	// Multiprocessor filter: with the filter on, a low qualifying bit (the ninth bit
	// or the stop bit, depending on the mode) withholds the receive flag.
	function automatic logic filter_pass(input logic mp_en, input logic qual);
		filter_pass = !(mp_en && !qual);
	endfunction : filter_pass

	// Read data for one register; unmapped offsets read as zero.
	function automatic logic [31:0] read_word(
		input logic [7:0]  adr,
		input logic [7:0]  ctrl,
		input logic [3:0]  stat,
		input logic [7:0]  rxbuf,
		input logic [15:0] baud
	);
		if (hit(adr, `CTRL_OFS))
			read_word = {24'h000000, ctrl};
		else if (hit(adr, `STAT_OFS))
			read_word = {28'h0000000, stat};
		else if (hit(adr, `RXDATA_OFS))
			read_word = {24'h000000, rxbuf};
		else if (hit(adr, `BAUD_OFS))
			read_word = {16'h0000, baud};
		else
			read_word = 32'h00000000;
	endfunction : read_word

	////////////////////////////////////////////////////////////////////////////////
	// Only byte lane 0 carries transmit data into the queue.
	sport_fifo #(
		.WIDTH (8),
		.DEPTH (`FIFO_DEPTH),
		.AW    (`FIFO_AW)
	) u_txfifo (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.in_data   (wb_dat_i[7:0]),
		.in_valid  (push_tx),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);

	assign mode = mode_t'({s_q.ctrl[`BIT_MODE_HI], s_q.ctrl[`BIT_MODE_LO]});
	// A request is taken only while ack is low, so each strobe is answered once.
	assign wr   = wb_cyc_i && wb_stb_i && wb_we_i && !s_q.ack;
	assign rd   = wb_cyc_i && wb_stb_i && !wb_we_i && !s_q.ack;
	// A full FIFO stalls the write: the ack is withheld until a slot frees up.
	assign push_tx = wr && wb_sel_i[0] && hit(wb_adr_i, `TXDATA_OFS) && fifo_in_ready;

	assign wb_dat_o    = s_q.dat;
	assign wb_ack_o    = s_q.ack;
	assign txd_o       = s_q.txd;
	assign shift_clk_o = s_q.sclk;

	// Status word: queue has room, queue holds a byte, sending, receiving.
	assign stat_c = {fifo_in_ready, fifo_valid, s_q.tst != TX_IDLE, s_q.rst != RX_IDLE};

	always_comb
	begin
		case (mode)
			MODE_SHIFT:     div_lim = `FIXED_DIV_M0;
			MODE_UART9_FIX: div_lim = `FIXED_DIV_M2;
			default:        div_lim = s_q.baud;
		endcase
	end
	// Bit-time enable: one pulse per sixteenth of a bit in UART modes.
	assign tick = (s_q.div == '0);

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		s_d            = s_q;
		fifo_pop       = 1'b0;
		hw_set_tx      = 1'b0;
		hw_set_rx      = 1'b0;
		rx_ninth_bit_d = s_q.ctrl[`BIT_RX9];
		rx_ninth_we    = 1'b0;

		s_d.div = tick ? (div_lim - 16'h0001) : (s_q.div - 16'h0001);
		s_d.rxd_p = rxd_i;

		// Transmitter: start bit, data LSB first, optional ninth bit, stop bit; shift mode sends the eight data bits alone.
		// The shifter refills with ones, so the line rests at the stop level between frames.
		case (s_q.tst)
			TX_IDLE:
			begin
				s_d.txd  = 1'b1;
				s_d.sclk = 1'b1;
				if (fifo_valid)
				begin
					fifo_pop = 1'b1;
					s_d.tst  = TX_SHIFT;
					s_d.tcnt = 4'h0;
					if (mode == MODE_SHIFT)
					begin
						s_d.tsh   = {3'b111, fifo_out};
						s_d.tbits = 4'h8;
					end
					else if (is_nine(mode))
					begin
						s_d.tsh   = {1'b1, s_q.ctrl[`BIT_TX9], fifo_out, 1'b0};
						s_d.tbits = 4'hB;
					end
					else
					begin
						s_d.tsh   = {2'b11, fifo_out, 1'b0};
						s_d.tbits = 4'hA;
					end
					// The byte moved into the shifter, so software may write another.
					hw_set_tx = 1'b1;
				end
			end
			TX_SHIFT:
			begin
				if (tick)
				begin
					s_d.txd  = s_q.tsh[0];
					s_d.sclk = (mode == MODE_SHIFT) ? s_q.tcnt[3] : 1'b1;
					s_d.tcnt = s_q.tcnt + 4'h1;
					if (s_q.tcnt == 4'hF)
					begin
						s_d.tsh   = {1'b1, s_q.tsh[10:1]};
						s_d.tbits = s_q.tbits - 4'h1;
						if (s_q.tbits == 4'h1)
							s_d.tst = TX_IDLE;
					end
				end
			end
			default: s_d.tst = TX_IDLE;
		endcase

		// Receiver: sampled at mid-bit with the sixteen-phase tick.
		// The start bit is checked again at its middle, so a short glitch is ignored.
		// A byte that is not read in time is simply replaced by the next one.
		case (s_q.rst)
			RX_IDLE:
			begin
				if (s_q.ctrl[`BIT_RX_EN] && s_q.rxd_p && !rxd_i)
				begin
					s_d.rst  = RX_START;
					s_d.rph  = 4'h0;
					s_d.rcnt = 4'h0;
				end
			end
			RX_START:
			begin
				if (tick)
				begin
					s_d.rph = s_q.rph + 4'h1;
					if (s_q.rph == 4'h7)
						s_d.rst = rxd_i ? RX_IDLE : RX_DATA;
					if (s_q.rph == 4'h7)
						s_d.rph = 4'h0;
				end
			end
			RX_DATA:
			begin
				if (tick)
				begin
					s_d.rph = s_q.rph + 4'h1;
					if (s_q.rph == 4'hF)
					begin
						s_d.rsh  = {rxd_i, s_q.rsh[8:1]};
						s_d.rcnt = s_q.rcnt + 4'h1;
						if (s_q.rcnt == (is_nine(mode) ? 4'h8 : 4'h7))
							s_d.rst = RX_STOP;
						// Shift mode ends after the eighth bit time.
						if (mode == MODE_SHIFT && s_q.rcnt == 4'h7)
						begin
							s_d.rst   = RX_IDLE;
							s_d.rxbuf = {rxd_i, s_q.rsh[8:2]};
							hw_set_rx = 1'b1;
						end
					end
				end
			end
			RX_STOP:
			begin
				if (tick && s_q.rph == 4'hF)
				begin
					s_d.rst = RX_IDLE;
					if (is_nine(mode))
					begin
						s_d.rxbuf      = s_q.rsh[7:0];
						rx_ninth_bit_d = s_q.rsh[8];
						rx_ninth_we    = 1'b1;
						hw_set_rx      = filter_pass(s_q.ctrl[`BIT_MP_EN], s_q.rsh[8]);
					end
					else
					begin
						s_d.rxbuf = s_q.rsh[8:1];
						if (!s_q.ctrl[`BIT_MP_EN])
						begin
							rx_ninth_bit_d = rxd_i;
							rx_ninth_we    = 1'b1;
						end
						hw_set_rx = filter_pass(s_q.ctrl[`BIT_MP_EN], rxd_i);
					end
				end
				else if (tick)
					s_d.rph = s_q.rph + 4'h1;
			end
			default: s_d.rst = RX_IDLE;
		endcase
		// Shift mode never writes rx_ninth_bit.
		if (mode == MODE_SHIFT)
			rx_ninth_we = 1'b0;

		// Register bus: one-cycle answer except a transmit write to a full queue, which waits; ack dropped the cycle after.
		s_d.ack = 1'b0;
		if (wr && (!hit(wb_adr_i, `TXDATA_OFS) || fifo_in_ready))
		begin
			s_d.ack = 1'b1;
			if (hit(wb_adr_i, `CTRL_OFS) && wb_sel_i[0])
				s_d.ctrl = wb_dat_i[7:0];
			if (hit(wb_adr_i, `BAUD_OFS))
			begin
				if (wb_sel_i[0])
					s_d.baud[7:0] = wb_dat_i[7:0];
				if (wb_sel_i[1])
					s_d.baud[15:8] = wb_dat_i[15:8];
			end
		end
		if (rd)
		begin
			s_d.ack = 1'b1;
			s_d.dat = read_word(wb_adr_i, s_q.ctrl, stat_c, s_q.rxbuf, s_q.baud);
		end

		// Hardware updates after the bus write; flags are only set here, never cleared.
		if (rx_ninth_we)
			s_d.ctrl[`BIT_RX9] = rx_ninth_bit_d;
		if (hw_set_tx)
			s_d.ctrl[`BIT_TX_DONE] = 1'b1;
		if (hw_set_rx)
			s_d.ctrl[`BIT_RX_DONE] = 1'b1;
	end

	// The line outputs reset to their idle level, so a peer sees no false start bit.
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
		begin
			s_q       <= '0;
			s_q.ctrl  <= `CTRL_RESET;
			s_q.baud  <= `BAUD_RESET;
			s_q.txd   <= 1'b1;
			s_q.sclk  <= 1'b1;
			s_q.rxd_p <= 1'b1;
		end
		else
			s_q <= s_d;
endmodule : sport_ctrl

// File: verif/sport_ctrl_sva.sv
// Port-level assertions on the serial port control block, with their bind.
`timescale 1ns/100ps
`include "sport_defs.svh"
module sport_ctrl_chk (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        rxd_i,
	input wire logic        shift_clk_o
);
	logic [7:0] cfg_q;
	logic [1:0] fl_q;
	logic       seen_q, wr_q, low_q, ren_q, push_q;
	wire        rd = wb_ack_o && !wb_we_i && wb_adr_i == `CTRL_OFS;
	wire        wr = wb_ack_o && wb_we_i && wb_adr_i == `CTRL_OFS;
	////////////////////////////////////////
	// History since the last control read (since reset for seen_q and push_q), so a new flag can be tied to its cause.
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			{cfg_q, fl_q, seen_q, wr_q, low_q, ren_q, push_q} <= '0;
		else
		begin
			if (wr)
				cfg_q <= wb_dat_i[7:0];
			if (rd)
				fl_q <= wb_dat_o[1:0];
			seen_q <= seen_q || rd;
			wr_q   <= wr || (wr_q && !rd);
			low_q  <= !rxd_i || (low_q && !rd);
			ren_q  <= cfg_q[4] || (ren_q && !rd);
			push_q <= push_q || (wb_ack_o && wb_we_i && wb_adr_i == `TXDATA_OFS);
		end
	////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_rd; rd; endsequence
	sequence s_new(b); rd ##0 (seen_q && !fl_q[b] && wb_dat_o[b]); endsequence
	property p_mode; s_rd |-> wb_dat_o[7:6] == cfg_q[7:6]; endproperty
	a_mode: assert property (p_mode) else $error("mode readback");
	property p_mp; s_rd |-> wb_dat_o[5] == cfg_q[5]; endproperty
	a_mp: assert property (p_mp) else $error("filter bit readback");
	property p_tx9; s_rd |-> wb_dat_o[3] == cfg_q[3]; endproperty
	a_tx9: assert property (p_tx9) else $error("tx ninth readback");
	property p_keep; s_rd ##0 (seen_q && !wr_q) |-> (fl_q & ~wb_dat_o[1:0]) == 2'h0; endproperty
	a_keep: assert property (p_keep) else $error("flag cleared by itself");
	property p_rxsrc; s_new(0) |-> low_q; endproperty
	a_rxsrc: assert property (p_rxsrc) else $error("rx flag without frame");
	property p_rxgate; s_new(0) |-> ren_q; endproperty
	a_rxgate: assert property (p_rxgate) else $error("rx flag while disabled");
	property p_txsrc; s_new(1) |-> push_q; endproperty
	a_txsrc: assert property (p_txsrc) else $error("tx flag without byte");
	property p_shclk; $fell(shift_clk_o) |-> $past(cfg_q[7:6]) == 2'h0; endproperty
	a_shclk: assert property (p_shclk) else $error("shift clock outside mode 0");
endmodule : sport_ctrl_chk
bind sport_ctrl sport_ctrl_chk chk (.sys_clk, .rst_n, .wb_we_i, .wb_adr_i, .wb_dat_i,
	.wb_dat_o, .wb_ack_o, .rxd_i, .shift_clk_o);

// File: verif/serial_peer.sv
// Peer node on the serial line: frames bytes into the block and decodes its output.
`timescale 1ns/100ps
module serial_peer (
	input  wire logic       sys_clk,
	input  wire logic [9:0] bit_cyc,
	input  wire logic       line_i,
	output logic            line_o,
	output logic [9:0]      got,
	output int              got_cnt
);
	initial
	begin
		line_o = 1'b1;
		got_cnt = 0;
	end
	task automatic send(input logic [8:0] d, input logic nine, input logic stop);
		logic [10:0] fr;
		fr = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
		for (int i = 0; i < 11; i++)
		begin
			@(posedge sys_clk);
			line_o <= fr[i];
			repeat (bit_cyc - 10'h1) @(posedge sys_clk);
		end
		@(posedge sys_clk);
		// The line has a pull-up, so a broken stop bit must not leave it low.
		line_o <= 1'b1;
	endtask : send
	always
	begin
		@(negedge line_i);
		repeat (bit_cyc / 2) @(posedge sys_clk);
		for (int i = 0; i < 10; i++)
		begin
			repeat (bit_cyc) @(posedge sys_clk);
			got[i] <= line_i;
		end
		got_cnt <= got_cnt + 1;
	end
endmodule : serial_peer

// File: verif/sport_ctrl_tb.sv
// Self-checking bench for the serial port control block.
`timescale 1ns/100ps
`include "sport_defs.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module sport_ctrl_tb;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, rd_v;
	logic        ack, txd, rxd, shclk;
	logic [9:0]  bit_cyc = 10'h100;
	logic [9:0]  got;
	int          got_cnt;
	int          error_cnt = 0;
	int          total_checks = 0;
	always #2.5 sys_clk = ~sys_clk;
	sport_ctrl dut (.sys_clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.rxd_i(rxd), .txd_o(txd), .shift_clk_o(shclk));
	serial_peer peer (.sys_clk, .bit_cyc, .line_i(txd), .line_o(rxd), .got, .got_cnt);
	////////////////////////////////////////
	task automatic end_sim;
		if (error_cnt == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (ack !== 1'b1 && n < 4000);
		rd_v = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n == 4000)
		begin
			error_cnt++;
			end_sim();
		end
	endtask : wb
	task automatic chk_ctl(input logic [7:0] m, input logic [7:0] e, input string s);
		wb(`CTRL_OFS, 1'b0, 32'h0);
		`CHK(s, e, rd_v[7:0] & m)
	endtask : chk_ctl
	task automatic wait_rx(input int t);
		int n;
		for (n = 0; n < 8000 && got_cnt < t; n++)
			@(posedge sys_clk);
		if (n == 8000)
		begin
			error_cnt++;
			end_sim();
		end
	endtask : wait_rx
	////////////////////////////////////////
	task automatic t_regs;
		chk_ctl(8'hFF, `CTRL_RESET, "ctrl reset");
		wb(`BAUD_OFS, 1'b0, 32'h0);
		`CHK("baud reset", `BAUD_RESET, rd_v[15:0])
		wb(8'h20, 1'b0, 32'h0);
		`CHK("unmapped", 32'h0, rd_v)
	endtask : t_regs
	// Rows: shift, disabled, plain 8-bit, filtered 8-bit, filtered and plain 9-bit, fixed rate.
	task automatic t_filter;
		logic [7:0] cf[9] = '{8'h10, 8'h40, 8'h50, 8'h70, 8'h70, 8'hF0, 8'hF0, 8'hD0, 8'h90};
		logic [7:0] mk[9] = '{8'h05, 8'h01, 8'h05, 8'h01, 8'h01, 8'h01, 8'h05, 8'h05, 8'h05};
		logic [7:0] ex[9] = '{8'h01, 8'h00, 8'h05, 8'h00, 8'h01, 8'h00, 8'h05, 8'h01, 8'h05};
		logic [8:0] nb = 9'h140;
		logic [8:0] sp = 9'h1F7;
		for (int i = 0; i < 9; i++)
		begin
			bit_cyc <= cf[i][7:6] == 2'h2 ? 10'h200 : 10'h100;
			wb(`CTRL_OFS, 1'b1, {24'h0, cf[i]});
			peer.send({nb[i], 8'hC3}, cf[i][7], sp[i]);
			repeat (64) @(posedge sys_clk);
			chk_ctl(mk[i], ex[i], "rx flags");
		end
		repeat (300) @(posedge sys_clk);
		chk_ctl(8'h05, 8'h05, "flags held");
		wb(`RXDATA_OFS, 1'b0, 32'h0);
		`CHK("rx data", 8'hC3, rd_v[7:0])
		wb(`CTRL_OFS, 1'b1, 32'h90);
		chk_ctl(8'h03, 8'h00, "flags cleared");
	endtask : t_filter
	task automatic t_fifo;
		int n0;
		bit_cyc <= 10'h100;
		wb(`CTRL_OFS, 1'b1, 32'hC0);
		n0 = got_cnt;
		for (int k = 0; k < 6; k++)
			wb(`TXDATA_OFS, 1'b1, 32'h10 + k);
		wb(`STAT_OFS, 1'b0, 32'h0);
		`CHK("fifo full", 8'h02, rd_v[7:0] & 8'h0A)
		for (int k = 0; k < 6; k++)
		begin
			wait_rx(n0 + k + 1);
			`CHK("fifo order", {2'b10, 8'h10 + 8'(k)}, got)
		end
	endtask : t_fifo
	task automatic t_tx;
		logic [7:0] cf[3] = '{8'h88, 8'hC0, 8'h08};
		logic       lo;
		lo = 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			bit_cyc <= cf[i][7:6] == 2'h2 ? 10'h200 : 10'h100;
			wb(`CTRL_OFS, 1'b1, {24'h0, cf[i]});
			chk_ctl(8'h02, 8'h00, "tx idle");
			wb(`TXDATA_OFS, 1'b1, 32'h5A);
			if (cf[i][7])
			begin
				wait_rx(got_cnt + 1);
				`CHK("tx frame", {1'b1, cf[i][3], 8'h5A}, got)
			end
			else
			begin
				repeat (3000)
				begin
					@(posedge sys_clk);
					lo |= !shclk;
				end
				`CHK("shift clock", 1'b1, lo)
			end
			chk_ctl(8'h02, 8'h02, "tx done");
		end
	endtask : t_tx
	initial
	begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_regs();
		t_filter();
		t_fifo();
		t_tx();
		end_sim();
	end
endmodule : sport_ctrl_tb
